// ==== design/iats_regs.vh ====
// Register offsets, field positions, reset values and timing counts of the trigger sequencer
`ifndef IATS_REGS_VH
`define IATS_REGS_VH

// Register byte offsets
`define IATS_CTRL_OFS      12'h000
`define IATS_CMD_OFS       12'h004
`define IATS_BURST_OFS     12'h008
`define IATS_EXP_OFS       12'h00c
`define IATS_RDO_OFS       12'h010
`define IATS_PERIOD_OFS    12'h014
`define IATS_STATUS_OFS    12'h018
`define IATS_IRQ_STAT_OFS  12'h01c
`define IATS_IRQ_MASK_OFS  12'h020
`define IATS_COUNTS_OFS    12'h024

// Control register fields
`define IATS_CTRL_AST_EN   0
`define IATS_CTRL_AST_SRC  1
`define IATS_CTRL_FST_EN   2
`define IATS_CTRL_FST_SRC  3
`define IATS_CTRL_CONT     4
`define IATS_CTRL_RESET    32'h0000_0015

// Command register fields, write-one pulses
`define IATS_CMD_ACQ_START 0
`define IATS_CMD_ACQ_STOP  1
`define IATS_CMD_AST_SW    2
`define IATS_CMD_FST_SW    3

// Interrupt event bits
`define IATS_EV_AST        0
`define IATS_EV_FRAME      1
`define IATS_EV_BURST      2
`define IATS_EV_REJECT     3
`define IATS_EV_DISCARD    4
`define IATS_EV_W          5

// Reset values of burst length and timing, in pclk cycles
`define IATS_BURST_RESET   16'h0003
`define IATS_EXP_RESET     24'h000064
`define IATS_RDO_RESET     24'h0000c8
`define IATS_PERIOD_RESET  24'h000190

`endif

// ==== design/iats_sequencer.v ====
// Acquisition and frame trigger sequencer with overlapped exposure control and APB registers
//
// Functional notes
// R01: Each software acquisition-start command is one acquisition start when enabled.
// R02: Accepted acquisition start moves state from wait-start to wait-frame.
// R03: Count frames; on reaching burst count return to waiting for acquisition start; code does so only in continuous mode, otherwise it goes idle.
// R04: After a burst, no frames until a new acquisition start.
// R05: Rising edge on the line input is one frame start when enabled.
// R06: Frame starts are honoured only in wait-frame state; others discarded.
// R07: Frame starts after burst completion are ignored and produce no frame.
// R08: Exposure precedes readout; readout starts only after exposure ends.
// R09: A new exposure may begin while the previous readout runs.
// R10: Overlap follows from trigger timing alone, no mode setting.
// R11: Triggering party must not start exposure during a running exposure.
// R12: Triggering party must not end exposure before prior readout completes.
// R13: Reject triggers that start during exposure or would end before readout done.
// R14: Provide a trigger-ready output telling when triggering is safe.
// R15: A disabled trigger type is generated internally.
// R16: Trigger-ready rises when safe, falls at acquisition start, rises again; code keeps it low until acquisition start and drops it at each frame start.
// R17: Synchronise the line input and detect each rising edge once.
// R18: Continuous mode repeats start-and-burst cycles until software stops.
`timescale 1ns/10ps
`default_nettype none
`include "iats_regs.vh"

module iats_sequencer
(
  input  wire        pclk,        // APB clock, 25 MHz
  input  wire        presetn,     // Asynchronous reset, active low
  input  wire        psel,        // APB select
  input  wire        penable,     // APB access phase
  input  wire        pwrite,      // APB write
  input  wire [11:0] paddr,       // APB byte address
  input  wire [31:0] pwdata,      // APB write data
  output reg  [31:0] prdata,      // APB read data
  output reg         pready,      // APB ready
  output reg         pslverr,     // APB error, unmapped address
  input  wire        line_in,     // External trigger input line
  output reg         exposing,    // Sensor exposure running
  output reg         reading,     // Sensor readout running
  output reg         trig_ready,  // Safe to trigger a new exposure
  output reg         wait_ast,    // Waiting for acquisition start
  output reg         irq          // Interrupt, level
);

  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_WAST  = 3'b010;
  localparam [2:0] ST_WFST  = 3'b100;

  reg  [31:0] ctrl;
  reg  [15:0] burst_len;
  reg  [23:0] exp_time;
  reg  [23:0] rdo_time;
  reg  [23:0] period;
  reg  [4:0]  irq_stat;
  reg  [4:0]  irq_mask;
  reg  [2:0]  state;
  reg  [15:0] frame_cnt;
  reg  [15:0] frames_total;
  reg  [23:0] exp_cnt;
  reg  [23:0] rdo_cnt;
  reg  [23:0] int_cnt;
  reg         line_s1;
  reg         line_s2;
  reg         line_d;
  reg         acq_on;
  reg  [3:0]  cmd_pulse;
  reg  [4:0]  next_ev;

  wire        wr_en = psel & penable & pwrite & pready;
  wire        rd_en = psel & penable & ~pwrite & pready;
  wire        line_rise = line_s2 & ~line_d;

  // Decode of an address to a mapped register
  function mapped;
    input [11:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `IATS_COUNTS_OFS);
    end
  endfunction

  // Remaining readout cycles exceed the exposure time: starting now would end too early
  function too_early;
    input [23:0] rdo_left;
    input [23:0] texp;
    begin
      too_early = rdo_left > texp;
    end
  endfunction

  // Internally generated triggers for disabled trigger types
  wire int_tick = (int_cnt == 24'h000000);
  wire ast_ev = ctrl[`IATS_CTRL_AST_EN] ?
                (ctrl[`IATS_CTRL_AST_SRC] ? cmd_pulse[`IATS_CMD_AST_SW] : line_rise) // see R01
                : 1'b1;                                                        // see R15
  wire fst_ev = ctrl[`IATS_CTRL_FST_EN] ?
                (ctrl[`IATS_CTRL_FST_SRC] ? cmd_pulse[`IATS_CMD_FST_SW] : line_rise) // see R05
                : int_tick;                                                    // see R15

  // Exposure may start only when none runs and it cannot end before readout is done
  wire safe = ~exposing & ~too_early(rdo_cnt, exp_time);   // see R13
  wire fst_take = (state == ST_WFST) & fst_ev & safe;      // see R06
  wire fst_rej  = (state == ST_WFST) & fst_ev & ~safe;     // see R13
  wire fst_drop = (state != ST_WFST) & fst_ev & ctrl[`IATS_CTRL_FST_EN]; // see R07
  wire last_frm = fst_take & (frame_cnt + 16'h0001 >= burst_len);

  // Line synchroniser and edge detector
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_s1 <= 1'b0;
      line_s2 <= 1'b0;
      line_d  <= 1'b0;
    end
    else
    begin
      line_s1 <= line_in;  // see R17
      line_s2 <= line_s1;
      line_d  <= line_s2;
    end
  end

  // APB slave, zero wait state
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl      <= `IATS_CTRL_RESET;
      burst_len <= `IATS_BURST_RESET;
      exp_time  <= `IATS_EXP_RESET;
      rdo_time  <= `IATS_RDO_RESET;
      period    <= `IATS_PERIOD_RESET;
      irq_mask  <= 5'h00;
      cmd_pulse <= 4'h0;
      prdata    <= 32'h00000000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end
    else
    begin
      pready    <= psel & ~penable;
      pslverr   <= psel & ~penable & ~mapped(paddr);
      cmd_pulse <= 4'h0;
      if (wr_en && mapped(paddr))
      begin
        case (paddr)
          `IATS_CTRL_OFS:     ctrl      <= {27'h0000000, pwdata[4:0]};
          `IATS_CMD_OFS:      cmd_pulse <= pwdata[3:0];
          `IATS_BURST_OFS:    burst_len <= pwdata[15:0];
          `IATS_EXP_OFS:      exp_time  <= pwdata[23:0];
          `IATS_RDO_OFS:      rdo_time  <= pwdata[23:0];
          `IATS_PERIOD_OFS:   period    <= pwdata[23:0];
          `IATS_IRQ_MASK_OFS: irq_mask  <= pwdata[4:0];
          default:            ;
        endcase
      end
      if (psel && !penable)
      begin
        case (paddr)
          `IATS_CTRL_OFS:     prdata <= ctrl;
          `IATS_BURST_OFS:    prdata <= {16'h0000, burst_len};
          `IATS_EXP_OFS:      prdata <= {8'h00, exp_time};
          `IATS_RDO_OFS:      prdata <= {8'h00, rdo_time};
          `IATS_PERIOD_OFS:   prdata <= {8'h00, period};
          `IATS_STATUS_OFS:   prdata <= {25'h0000000, trig_ready, reading, exposing,
                                         acq_on, state};
          `IATS_IRQ_STAT_OFS: prdata <= {27'h0000000, irq_stat};
          `IATS_IRQ_MASK_OFS: prdata <= {27'h0000000, irq_mask};
          `IATS_COUNTS_OFS:   prdata <= {frames_total, frame_cnt};
          default:            prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Acquisition state machine
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state        <= ST_IDLE;
      acq_on       <= 1'b0;
      frame_cnt    <= 16'h0000;
      frames_total <= 16'h0000;
    end
    else
    begin
      if (cmd_pulse[`IATS_CMD_ACQ_STOP])
      begin
        acq_on <= 1'b0;
        state  <= ST_IDLE;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            if (cmd_pulse[`IATS_CMD_ACQ_START])
            begin
              acq_on <= 1'b1;
              state  <= ST_WAST;
            end
          end
          ST_WAST:
          begin
            if (ast_ev)                  // see R04
            begin
              frame_cnt <= 16'h0000;
              state     <= ST_WFST;      // see R02
            end
          end
          ST_WFST:
          begin
            if (fst_take)
            begin
              frame_cnt    <= frame_cnt + 16'h0001;  // see R03
              frames_total <= frames_total + 16'h0001;
              if (last_frm)
              begin
                // Non-continuous mode ends acquisition after one burst
                if (ctrl[`IATS_CTRL_CONT])
                  state <= ST_WAST;      // see R18
                else
                begin
                  state  <= ST_IDLE;
                  acq_on <= 1'b0;
                end
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Exposure and readout engines; a new exposure may overlap the readout
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exposing   <= 1'b0;
      reading    <= 1'b0;
      exp_cnt    <= 24'h000000;
      rdo_cnt    <= 24'h000000;
      int_cnt    <= `IATS_PERIOD_RESET;
      trig_ready <= 1'b0;
      wait_ast   <= 1'b0;
    end
    else
    begin
      int_cnt <= (int_tick || state != ST_WFST) ? period : int_cnt - 24'h000001;
      if (fst_take)                     // see R09 see R10
      begin
        exposing <= 1'b1;
        exp_cnt  <= (exp_time == 24'h000000) ? 24'h000000 : exp_time - 24'h000001;
      end
      else if (exposing)
      begin
        if (exp_cnt == 24'h000000)
        begin
          exposing <= 1'b0;
          reading  <= 1'b1;             // see R08
          rdo_cnt  <= rdo_time;
        end
        else
          exp_cnt <= exp_cnt - 24'h000001;
      end
      if (reading && !(exposing && exp_cnt == 24'h000000))
      begin
        if (rdo_cnt <= 24'h000001)
        begin
          reading <= 1'b0;
          rdo_cnt <= 24'h000000;
        end
        else
          rdo_cnt <= rdo_cnt - 24'h000001;
      end
      trig_ready <= (state == ST_WFST) & safe & ~fst_take;  // see R14 see R16
      wait_ast   <= (state == ST_WAST) & ~ast_ev;
    end
  end

  // Sticky interrupt status; set wins over the clear on read
  always @*
  begin
    next_ev = 5'h00;
    next_ev[`IATS_EV_AST]     = (state == ST_WAST) & ast_ev;
    next_ev[`IATS_EV_FRAME]   = fst_take;
    next_ev[`IATS_EV_BURST]   = last_frm;
    next_ev[`IATS_EV_REJECT]  = fst_rej;
    next_ev[`IATS_EV_DISCARD] = fst_drop;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat <= 5'h00;
      irq      <= 1'b0;
    end
    else
    begin
      // Clear only the bits the read returned, so an event landing after the capture survives
      if (rd_en && paddr == `IATS_IRQ_STAT_OFS)
        irq_stat <= (irq_stat & ~prdata[4:0]) | next_ev;
      else
        irq_stat <= irq_stat | next_ev;
      irq <= |(irq_stat & irq_mask);
    end
  end

endmodule
`default_nettype wire

// ==== sim/iats_seq_assertions.sv ====
// Port checks for the trigger sequencer
`timescale 1ns/10ps
`default_nettype none
module iats_seq_chk
(
  input wire logic        pclk,       // Clock
  input wire logic        presetn,    // Reset, low
  input wire logic        psel,       // Select
  input wire logic        penable,    // Access
  input wire logic        pwrite,     // Write
  input wire logic [31:0] prdata,     // Read data
  input wire logic        pready,     // Ready
  input wire logic        pslverr,    // Error
  input wire logic        exposing,   // Exposure
  input wire logic        reading,    // Readout
  input wire logic        trig_ready, // Safe to trigger
  input wire logic        wait_ast    // Awaiting start
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  exp_then_read_a: assert property ($fell(exposing) |-> reading)
    else $error("no readout after exposure");
  read_after_exp_a: assert property ($rose(reading) |-> $fell(exposing))
    else $error("readout began without exposure end");
  ready_no_exp_a: assert property (exposing |-> !trig_ready)
    else $error("ready during exposure");
  ready_no_ast_a: assert property (trig_ready |-> !wait_ast)
    else $error("ready while awaiting start");
  ast_no_frame_a: assert property ($past(wait_ast) |-> !$rose(exposing))
    else $error("frame while awaiting start");
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  apb_only_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_zero_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("error read not zero");
  cover property ($rose(exposing) && reading);
  cover property ($fell(wait_ast));
  cover property (pslverr);
endmodule
bind iats_sequencer iats_seq_chk chk_u
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .exposing(exposing),
  .reading(reading), .trig_ready(trig_ready), .wait_ast(wait_ast)
);
`default_nettype wire

// ==== sim/iats_trig_src.sv ====
// Line trigger source driving the external trigger input
`timescale 1ns/10ps
`default_nettype none
module iats_trig_src
(
  input  wire logic pclk,       // Clock
  input  wire logic presetn,    // Reset, low
  input  wire logic fire,       // Request one pulse
  input  wire logic polite,     // Wait for ready
  input  wire logic trig_ready, // Safe to trigger
  output var  logic line_in,    // Line, idle low
  output var  logic busy        // Pulse pending
);
  logic [2:0] cnt;
  logic       sent;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_in <= 1'b0;
      busy <= 1'b0;
      sent <= 1'b0;
      cnt <= 3'h0;
    end
    else if (fire && !busy)
      busy <= 1'b1;
    else if (line_in)
    begin
      cnt <= cnt - 3'h1;
      line_in <= (cnt != 3'h1);
    end
    else if (busy && sent)
    begin
      busy <= 1'b0;
      sent <= 1'b0;
    end
    else if (busy && (!polite || trig_ready))
    begin
      line_in <= 1'b1;
      sent <= 1'b1;
      cnt <= 3'h6;
    end
  end
endmodule
`default_nettype wire

// ==== sim/test_image_acquisition_trigger_sequencer.sv ====
// Self-checking bench for the trigger sequencer
`timescale 1ns/10ps
`default_nettype none
`include "iats_regs.vh"
module test_image_acquisition_trigger_sequencer;
  logic        pclk, presetn, psel, penable, pwrite, fire, pol, ovl, pe, pr, rerr;
  logic        pready, pslverr, line_in, exposing, reading, trig_ready, wait_ast, irq, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  integer      miscompares, cmp_count, nfr, b, seed, elen, rlen, texp_m, trdo_m;
  iats_sequencer dut_u
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_in(line_in), .exposing(exposing), .reading(reading), .trig_ready(trig_ready),
    .wait_ast(wait_ast), .irq(irq)
  );
  iats_trig_src src_u
  (
    .pclk(pclk), .presetn(presetn), .fire(fire), .polite(pol),
    .trig_ready(trig_ready), .line_in(line_in), .busy(busy)
  );
  always #20 pclk = ~pclk;
  // Model of frame timing: frame count, overlap, exposure and readout lengths
  always @(posedge pclk)
  begin
    if (!presetn)
    begin
      pe <= 1'b0;
      pr <= 1'b0;
      ovl <= 1'b0;
      nfr <= 0;
      elen <= 0;
      rlen <= 0;
    end
    else
    begin
      pe <= exposing;
      pr <= reading;
      if (exposing && !pe)
        nfr <= nfr + 1;
      if (exposing && reading)
        ovl <= 1'b1;
      elen <= exposing ? elen + 1 : 0;
      rlen <= reading ? rlen + 1 : 0;
      if (!exposing && pe)
        chk("exposure cycles", elen, texp_m);
      if (!reading && pr)
        chk("readout cycles", rlen, trdo_m);
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
  begin
    cmp_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
  begin
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      miscompares++;
    if (w && a == `IATS_EXP_OFS)
      texp_m = d;
    if (w && a == `IATS_RDO_OFS)
      trdo_m = d;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task pulse;
    integer n;
  begin
    @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (busy !== 1'b0 && n < 200);
    if (busy !== 1'b0)
      miscompares++;
  end
  endtask
  task summarize;
  begin
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  initial
  begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    summarize;
  end
  initial
  begin
    seed = $urandom(77338);
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    {fire, pol, miscompares, cmp_count} = 0;
    texp_m = `IATS_EXP_RESET;
    trdo_m = `IATS_RDO_RESET;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `IATS_CTRL_OFS, 0);
    chk("ctrl", rdat, `IATS_CTRL_RESET);
    apb(0, 12'h030, 0);
    chk("unmapped err", rerr, 1);
    chk("unmapped data", rdat, 0);
    b = 2 + $urandom % 3;
    apb(1, `IATS_EXP_OFS, 10);
    apb(1, `IATS_RDO_OFS, 8);
    apb(1, `IATS_IRQ_MASK_OFS, 32'h1f);
    apb(1, `IATS_BURST_OFS, b);
    apb(1, `IATS_CTRL_OFS, 32'h17);
    apb(1, `IATS_CMD_OFS, 1);
    repeat (3) @(posedge pclk);
    chk("wait start", wait_ast, 1);
    pulse;
    repeat (6) @(posedge pclk);
    chk("no frame", nfr, 0);
    chk("irq", irq, 1);
    apb(0, `IATS_IRQ_STAT_OFS, 0);
    chk("discard", rdat[`IATS_EV_DISCARD], 1);
    repeat (2) @(posedge pclk);
    chk("irq clear", irq, 0);
    apb(1, `IATS_CMD_OFS, 4);
    repeat (2) @(posedge pclk);
    chk("left start", wait_ast, 0);
    @(posedge pclk);
    chk("ready", trig_ready, 1);
    pol <= 1'b1;
    repeat (b) pulse;
    repeat (30) @(posedge pclk);
    chk("burst", nfr, b);
    chk("rewait", wait_ast, 1);
    chk("overlap", ovl, 1);
    pol <= 1'b0;
    pulse;
    repeat (30) @(posedge pclk);
    chk("ignored", nfr, b);
    apb(1, `IATS_EXP_OFS, 40);
    apb(1, `IATS_CMD_OFS, 4);
    pulse;
    chk("busy ready", trig_ready, 0);
    pulse;
    repeat (80) @(posedge pclk);
    apb(0, `IATS_IRQ_STAT_OFS, 0);
    chk("reject", rdat[`IATS_EV_REJECT], 1);
    chk("one frame", nfr, b + 1);
    apb(1, `IATS_CMD_OFS, 2);
    apb(1, `IATS_EXP_OFS, 4);
    apb(1, `IATS_PERIOD_OFS, 20);
    apb(1, `IATS_CTRL_OFS, 32'h13);
    apb(1, `IATS_CMD_OFS, 1);
    apb(1, `IATS_CMD_OFS, 4);
    repeat (200) @(posedge pclk);
    chk("internal", nfr, 2 * b + 1);
    chk("rearmed", wait_ast, 1);
    apb(1, `IATS_CMD_OFS, 2);
    apb(1, `IATS_CTRL_OFS, 32'h0c);
    apb(1, `IATS_CMD_OFS, 1);
    repeat (b)
    begin
      repeat (20) @(posedge pclk);
      apb(1, `IATS_CMD_OFS, 8);
    end
    repeat (20) @(posedge pclk);
    apb(1, `IATS_CMD_OFS, 8);
    repeat (20) @(posedge pclk);
    chk("single burst", nfr, 3 * b + 1);
    apb(0, `IATS_STATUS_OFS, 0);
    chk("idle status", rdat[6:0], 7'h01);
    apb(0, `IATS_COUNTS_OFS, 0);
    chk("counts", rdat, ((3 * b + 1) << 16) | b);
    summarize;
  end
endmodule
`default_nettype wire
